// *** hw/ind_consts.svh ***
// Register offsets, field positions, reset values and timing counts of the sensor interface.
//
// Behaviour
// - Entering the lowest power state restores every register to its default.
// - Writing b10 to power field of 0x0B enters shutdown when the write completes; here only if bit 1 of 0x05 is set, else the state is kept.
// - Reference clock toggling again leaves shutdown into sleep with default registers.
// - No conversions in shutdown; entry clears status; live errors reappear after exit.
// - Writing b01 to the power field selects sleep; registers are kept.
// - Writing b00 to the power field starts continuous active conversions.
// - In sleep the serial interface still reads and writes registers.
// - After power-up and after leaving shutdown the device is in sleep.
// - Interrupt reporting registers accept writes while active.
// - Status bit 7 at 0x20 flags that sensor oscillation has stopped.
// - Status bit 6 flags a finished resistance plus inductance conversion.
// - Status bits 5 to 2 carry the four threshold comparison results.
// - Status bit 0 shows power-on reset; host configures only after it clears.
// - Fine inductance status is readable at 0x3B.
// - Data-out pin can serve as interrupt for completion or comparator result.
// - A write with fewer than 16 clocks leaves the register unchanged.
// - Each further 8 clocks under chip select address the next register, same direction.
// - Writes apply on the eighth data clock; host keeps burst addresses up to 0x3F.
// - With comparator enabled the data-out pin shows a switch level.
// - Sleep and shutdown perform no conversions.
`ifndef IND_CONSTS_SVH
`define IND_CONSTS_SVH

`define REG_DEPTH        64
`define ADDR_LIMIT       7'h40
`define ADDR_ALT         7'h05
`define ADDR_IRQ_MODE    7'h0a
`define ADDR_POWER       7'h0b
`define ADDR_STATUS      7'h20
`define ADDR_FINE_INDUCTANCE_STATUS_REG  7'h3b
`define ADDR_RID         7'h3e
`define ADDR_CHIP_ID     7'h3f

`define BIT_SHUT_ALLOW   1
`define BIT_OSC_LOST     7
`define BIT_DONE         6
`define BIT_POR          0

`define CODE_ACTIVE      2'h0
`define CODE_SLEEP       2'h1
`define CODE_SHUT        2'h2

`define DEF_RANGE        8'h07
`define DEF_TC1          8'h90
`define DEF_TC2          8'ha0
`define DEF_INTERVAL     8'h03
`define DEF_POWER        8'h01

`define CLK_PERIOD_NS    100
`define POR_TIME_NS      2000
`define POR_CYCLES       ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hw/ind_pkg.sv ***
// Types shared by the sensor interface modules.
package ind_pkg;
	typedef enum logic [1:0] {
		PWR_POR    = 2'b00,
		PWR_SLEEP  = 2'b01,
		PWR_ACTIVE = 2'b10,
		PWR_SHUT   = 2'b11
	} power_state_t;
	typedef logic [7:0] reg_byte_t;
endpackage : ind_pkg

// *** hw/reg_mem.sv ***
// Register storage with defaults restored at reset and on request.
`timescale 1ns/1ps
`default_nettype none
`include "ind_consts.svh"
module reg_mem
	import ind_pkg::*;
(
	input  wire logic      clock_i,
	input  wire logic      rst_n_i,
	input  wire logic      restore_i,
	input  wire logic      we_i,
	input  wire logic [5:0] waddr_i,
	input  wire reg_byte_t wdata_i,
	input  wire logic [5:0] raddr_i,
	output reg_byte_t      rdata_o
);
	reg_byte_t mem_q [`REG_DEPTH];

	function automatic reg_byte_t default_of(input int unsigned idx);
		case (idx)
			1:       default_of = `DEF_RANGE;
			2:       default_of = `DEF_TC1;
			3:       default_of = `DEF_TC2;
			4:       default_of = `DEF_INTERVAL;
			11:      default_of = `DEF_POWER;
			default: default_of = 8'h00;
		endcase
	endfunction : default_of

	for (genvar i = 0; i < `REG_DEPTH; i++) begin : g_entry
		always_ff @(posedge clock_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				mem_q[i] <= default_of(i);
			end else if (restore_i) begin
				mem_q[i] <= default_of(i);
			end else if (we_i && waddr_i == 6'(i)) begin
				mem_q[i] <= wdata_i;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= mem_q[raddr_i];
		end
	end
endmodule : reg_mem
`default_nettype wire

// *** hw/spi_link.sv ***
// Serial link shifter running on the serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "ind_consts.svh"
module spi_link
	import ind_pkg::*;
(
	input  wire logic       sclk_i,
	input  wire logic       rst_n_i,
	input  wire logic       cs_n_i,
	input  wire logic       mosi_i,
	input  wire reg_byte_t  rd_data_i,
	output logic            sdo_o,
	output logic            wr_toggle_o,
	output logic [6:0]      wr_addr_o,
	output reg_byte_t       wr_data_o,
	output logic            rd_toggle_o,
	output logic [6:0]      rd_addr_o
);
	logic [2:0] bit_cnt_q;
	logic [6:0] shift_q;
	logic       cmd_done_q;
	logic       rw_q;
	logic [6:0] addr_q;
	logic       first_bit_q;
	reg_byte_t  tx_q;
	logic       sdo_q;
	reg_byte_t  rx_byte;
	logic       byte_end;
	logic       read_next;

	assign rx_byte   = {shift_q, mosi_i};
	assign byte_end  = (bit_cnt_q == 3'h7);
	assign read_next = cmd_done_q ? rw_q : rx_byte[7];

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			bit_cnt_q <= 3'h0;
			shift_q   <= 7'h00;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q   <= rx_byte[6:0];
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			cmd_done_q <= 1'b0;
			rw_q       <= 1'b0;
			addr_q     <= 7'h00;
		end else if (byte_end) begin
			if (!cmd_done_q) begin
				cmd_done_q <= 1'b1;
				rw_q       <= rx_byte[7];
				addr_q     <= rx_byte[6:0];
			end else begin
				addr_q <= addr_q + 7'h01;
			end
		end
	end

	// Events cross by toggle; address and data stay put until the next byte ends.
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_toggle_o <= 1'b0;
			wr_addr_o   <= 7'h00;
			wr_data_o   <= 8'h00;
		end else if (!cs_n_i && byte_end && cmd_done_q && !rw_q) begin
			wr_toggle_o <= ~wr_toggle_o;
			wr_addr_o   <= addr_q;
			wr_data_o   <= rx_byte;
		end
	end

	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_toggle_o <= 1'b0;
			rd_addr_o   <= 7'h00;
		end else if (!cs_n_i && byte_end && read_next) begin
			rd_toggle_o <= ~rd_toggle_o;
			rd_addr_o   <= cmd_done_q ? addr_q + 7'h01 : rx_byte[6:0];
		end
	end

	always_ff @(posedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			first_bit_q <= 1'b0;
			tx_q        <= 8'h00;
		end else begin
			first_bit_q <= byte_end && read_next;
			tx_q        <= first_bit_q ? {rd_data_i[6:0], 1'b0} : {tx_q[6:0], 1'b0};
		end
	end

	always_ff @(negedge sclk_i or posedge cs_n_i) begin
		if (cs_n_i) begin
			sdo_q <= 1'b0;
		end else begin
			sdo_q <= tx_q[7];
		end
	end

	// The first bit of a read byte comes straight from the answer word during the host's pause.
	assign sdo_o = first_bit_q ? rd_data_i[7] : sdo_q;
endmodule : spi_link
`default_nettype wire

// *** hw/inductive_sensor_spi_power_control.sv ***
// Top of the sensor serial interface with power state control and status reporting.
`timescale 1ns/1ps
`default_nettype none
`include "ind_consts.svh"
module inductive_sensor_spi_power_control
	import ind_pkg::*;
#(
	parameter logic [7:0] REV_ID  = 8'h5a, // Value is arbitrary.
	parameter logic [7:0] PART_ID = 8'ha5  // Value is arbitrary.
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       sclk_i,
	input  wire logic       chip_select_active_low_i,
	input  wire logic       mosi_i,
	output logic            sdo_o,
	output logic            sdo_oe_o,
	input  wire logic       reference_clock_input_i,
	input  wire logic       conv_done_i,
	input  wire logic [3:0] thr_flags_i,
	input  wire logic       osc_lost_i,
	input  wire reg_byte_t  fine_inductance_status_i,
	output logic            conv_enable_o,
	output power_state_t    power_state_o
);
	// ****************************************************************
	// Link and crossings
	// ****************************************************************
	logic         link_sdo;
	logic         wr_toggle;
	logic [6:0]   wr_addr;
	reg_byte_t    wr_data;
	logic         rd_toggle;
	logic [6:0]   rd_addr;
	reg_byte_t    rd_data_q;
	logic [2:0]   wr_sync_q;
	logic [2:0]   rd_sync_q;
	logic [2:0]   ref_sync_q;
	logic         wr_fire;
	logic         rd_fire;
	logic         ref_edge;

	spi_link u_link (
		.sclk_i      (sclk_i),
		.rst_n_i     (rst_n_i),
		.cs_n_i      (chip_select_active_low_i),
		.mosi_i      (mosi_i),
		.rd_data_i   (rd_data_q),
		.sdo_o       (link_sdo),
		.wr_toggle_o (wr_toggle),
		.wr_addr_o   (wr_addr),
		.wr_data_o   (wr_data),
		.rd_toggle_o (rd_toggle),
		.rd_addr_o   (rd_addr)
	);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_sync_q  <= 3'h0;
			rd_sync_q  <= 3'h0;
			ref_sync_q <= 3'h0;
		end else begin
			wr_sync_q  <= {wr_sync_q[1:0], wr_toggle};
			rd_sync_q  <= {rd_sync_q[1:0], rd_toggle};
			ref_sync_q <= {ref_sync_q[1:0], reference_clock_input_i};
		end
	end

	assign wr_fire  = wr_sync_q[2] ^ wr_sync_q[1];
	assign rd_fire  = rd_sync_q[2] ^ rd_sync_q[1];
	assign ref_edge = ref_sync_q[2] ^ ref_sync_q[1];

	// ****************************************************************
	// Power state
	// ****************************************************************
	power_state_t state_q;
	logic [7:0]   por_cnt_q;
	logic         shut_allow_q;
	logic [1:0]   irq_mode_q;
	logic         power_wr;
	logic         enter_shut;
	logic         mem_we;
	reg_byte_t    mem_rdata;

	assign power_wr   = wr_fire && wr_addr == `ADDR_POWER && state_q != PWR_SHUT;
	assign enter_shut = power_wr && wr_data[1:0] == `CODE_SHUT && shut_allow_q && state_q != PWR_POR;

	// Threshold and interrupt registers may change while converting; configuration waits for sleep.
	function automatic logic writable(input logic [6:0] addr, input power_state_t st);
		logic any_time;
		logic config_reg;
		any_time   = (addr >= 7'h06 && addr <= 7'h0b) || (addr >= 7'h16 && addr <= 7'h19);
		config_reg = (addr >= 7'h01 && addr <= 7'h05) || addr == 7'h0c || (addr >= 7'h30 && addr <= 7'h34);
		writable   = any_time || (config_reg && st != PWR_ACTIVE);
	endfunction : writable

	assign mem_we = wr_fire && state_q != PWR_SHUT && !enter_shut && writable(wr_addr, state_q);

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= PWR_POR;
		end else begin
			unique case (state_q)
				PWR_POR: begin
					if (por_cnt_q == 8'(`POR_CYCLES - 1)) begin
						state_q <= PWR_SLEEP;
					end
				end
				PWR_SLEEP, PWR_ACTIVE: begin
					if (enter_shut) begin
						state_q <= PWR_SHUT;
					end else if (power_wr && wr_data[1:0] == `CODE_SLEEP) begin
						state_q <= PWR_SLEEP;
					end else if (power_wr && wr_data[1:0] == `CODE_ACTIVE) begin
						state_q <= PWR_ACTIVE;
					end
				end
				PWR_SHUT: begin
					if (ref_edge) begin
						state_q <= PWR_SLEEP;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			por_cnt_q <= 8'h00;
		end else if (state_q == PWR_POR) begin
			por_cnt_q <= por_cnt_q + 8'h01;
		end
	end

	// Shadow copies of the fields that steer this logic; cleared with the register file.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			shut_allow_q <= 1'b0;
			irq_mode_q   <= 2'h0;
		end else if (enter_shut) begin
			shut_allow_q <= 1'b0;
			irq_mode_q   <= 2'h0;
		end else if (mem_we && wr_addr == `ADDR_ALT) begin
			shut_allow_q <= wr_data[`BIT_SHUT_ALLOW];
		end else if (mem_we && wr_addr == `ADDR_IRQ_MODE) begin
			irq_mode_q <= wr_data[1:0];
		end
	end

	reg_mem u_mem (
		.clock_i   (clock_i),
		.rst_n_i   (rst_n_i),
		.restore_i (enter_shut),
		.we_i      (mem_we),
		.waddr_i   (wr_addr[5:0]),
		.wdata_i   (wr_data),
		.raddr_i   (rd_addr[5:0]),
		.rdata_o   (mem_rdata)
	);

	assign conv_enable_o = (state_q == PWR_ACTIVE);
	assign power_state_o = state_q;

	// ****************************************************************
	// Status and read path
	// ****************************************************************
	logic       done_q;
	logic [3:0] thr_q;
	logic       rd_pend_q;
	logic       osc_flag;
	reg_byte_t  status;
	logic       conv_ok;
	logic       status_read;

	assign conv_ok     = conv_done_i && state_q == PWR_ACTIVE;
	assign status_read = rd_pend_q && rd_addr == `ADDR_STATUS;
	assign osc_flag    = osc_lost_i && state_q != PWR_SHUT;
	assign status      = {osc_flag, done_q, thr_q, 1'b0, state_q == PWR_POR};

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			done_q <= 1'b0;
		end else if (enter_shut) begin
			done_q <= 1'b0;
		end else if (conv_ok) begin
			done_q <= 1'b1;
		end else if (status_read) begin
			done_q <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			thr_q <= 4'h0;
		end else if (enter_shut) begin
			thr_q <= 4'h0;
		end else if (conv_ok) begin
			thr_q <= thr_flags_i;
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pend_q <= 1'b0;
		end else begin
			rd_pend_q <= rd_fire;
		end
	end

	// Each fetch is answered once and held until the next byte end asks again.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_data_q <= 8'h00;
		end else if (rd_pend_q) begin
			unique case (rd_addr)
				`ADDR_STATUS:     rd_data_q <= status;
				`ADDR_FINE_INDUCTANCE_STATUS_REG: rd_data_q <= fine_inductance_status_i;
				`ADDR_RID:        rd_data_q <= REV_ID;
				`ADDR_CHIP_ID:    rd_data_q <= PART_ID;
				default:          rd_data_q <= (rd_addr < `ADDR_LIMIT) ? mem_rdata : 8'h00;
			endcase
		end
	end

	// ****************************************************************
	// Data-out pin sharing
	// ****************************************************************
	logic irq_level_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_level_q <= 1'b1;
		end else begin
			unique case (irq_mode_q)
				2'h0: irq_level_q <= 1'b1;
				2'h1: irq_level_q <= ~done_q;
				2'h2: irq_level_q <= ~thr_q[3];
				2'h3: irq_level_q <= ~thr_q[1];
			endcase
		end
	end

	assign sdo_o    = chip_select_active_low_i ? irq_level_q : link_sdo;
	assign sdo_oe_o = !chip_select_active_low_i || irq_mode_q != 2'h0;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	shut_entry_a: assert property (enter_shut |=> state_q == PWR_SHUT)
		else $error("shutdown not entered after allowed power write");
	shut_guard_a: assert property (power_wr && wr_data[1:0] == `CODE_SHUT && !shut_allow_q
		|=> state_q != PWR_SHUT)
		else $error("shutdown entered without allow bit");
	shut_clear_a: assert property (state_q == PWR_SHUT |-> !done_q && thr_q == 4'h0 && !shut_allow_q
		&& irq_mode_q == 2'h0)
		else $error("state not cleared in shutdown");
	no_conv_a: assert property (state_q != PWR_ACTIVE |-> !conv_enable_o)
		else $error("conversions enabled outside active");
	wake_sleep_a: assert property (state_q == PWR_SHUT && ref_edge |=> state_q == PWR_SLEEP)
		else $error("reference clock did not wake to sleep");
	sleep_entry_a: assert property (power_wr && !enter_shut && wr_data[1:0] == `CODE_SLEEP
		&& state_q != PWR_POR |=> state_q == PWR_SLEEP)
		else $error("sleep code ignored");
	active_entry_a: assert property (power_wr && wr_data[1:0] == `CODE_ACTIVE && state_q != PWR_POR
		|=> conv_enable_o)
		else $error("active code ignored");
	por_exit_a: assert property ($fell(state_q == PWR_POR) |-> $past(por_cnt_q) == 8'(`POR_CYCLES - 1))
		else $error("power-on reset left at wrong count");
	por_bit_a: assert property (state_q == PWR_POR |-> status[`BIT_POR])
		else $error("power-on bit clear during reset");
	done_set_a: assert property (conv_ok && !enter_shut
		|=> done_q ##1 (done_q || $past(status_read) || $past(enter_shut)))
		else $error("conversion done flag lost");
	osc_flag_a: assert property (status_read && state_q != PWR_SHUT
		|=> rd_data_q[`BIT_OSC_LOST] == $past(osc_lost_i))
		else $error("oscillation lost not reported");
	irq_pin_a: assert property (irq_mode_q == 2'h1 && chip_select_active_low_i
		##1 irq_mode_q == 2'h1 && chip_select_active_low_i
		|-> sdo_o == ~$past(done_q) && sdo_oe_o)
		else $error("interrupt level wrong on data-out");
	fine_read_a: assert property (rd_pend_q && rd_addr == `ADDR_FINE_INDUCTANCE_STATUS_REG
		|=> rd_data_q == $past(fine_inductance_status_i))
		else $error("fine inductance status not returned");
	sleep_write_a: assert property (wr_fire && state_q == PWR_SLEEP && wr_addr == `ADDR_ALT |-> mem_we)
		else $error("register write refused in sleep");
	irq_write_a: assert property (wr_fire && state_q == PWR_ACTIVE && wr_addr == `ADDR_IRQ_MODE
		|=> irq_mode_q == $past(wr_data[1:0]))
		else $error("interrupt mode write refused while active");
	sleep_mute_a: assert property (state_q == PWR_SLEEP && conv_done_i && !enter_shut
		|=> thr_q == $past(thr_q) && (!done_q || $past(done_q)))
		else $error("conversion counted in sleep");
	wake_clear_a: assert property ($fell(state_q == PWR_SHUT) |-> thr_q == 4'h0 && !done_q)
		else $error("status not clear after leaving shutdown");

	// Cover points follow the power cycle, counted conversions, bursts and the shared pin.
	shut_cycle_c: cover property (enter_shut ##[1:1000] state_q == PWR_SLEEP);
	active_conv_c: cover property (state_q == PWR_ACTIVE && conv_done_i);
	burst_write_c: cover property (wr_fire ##[1:100] wr_fire);
	status_fetch_c: cover property (status_read && done_q);
	irq_switch_c: cover property (irq_mode_q != 2'h0 && chip_select_active_low_i && !sdo_o);
endmodule : inductive_sensor_spi_power_control
`default_nettype wire

// *** bench/spi_host_model.sv ***
// Host controller model that drives the serial link and the reference clock.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic       clock_i,
	input  wire logic       ref_run_i,
	input  wire logic       sdo_i,
	output logic            sclk_o,
	output logic            cs_n_o,
	output logic            mosi_o,
	output logic            ref_clk_o,
	output logic            rd_stb_o,
	output logic [7:0]      rd_byte_o
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
		ref_clk_o = 1'b0;
		rd_stb_o = 1'b0;
		rd_byte_o = 8'h00;
	end

	// The reference clock stops and sits low while shutdown is being prepared.
	always @(posedge clock_i) begin
		ref_clk_o <= ref_run_i & ~ref_clk_o;
	end

	// Pause between bytes so that writes and read fetches can cross domains.
	task automatic gap();
		repeat (12) @(posedge clock_i);
		#1.7;
	endtask : gap

	task automatic shift(input logic [7:0] tx, input int nb, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < nb; i++) begin
			mosi_o <= tx[7 - i];
			#3;
			sclk_o <= 1'b1;
			rx[7 - i] = sdo_i;
			#3;
			sclk_o <= 1'b0;
		end
	endtask : shift

	task automatic frame(input logic rd, input logic [6:0] addr, input int nbytes, input int last_bits,
		input logic [15:0] wd);
		logic [7:0] rx;
		cs_n_o <= 1'b0;
		gap();
		shift({rd, addr}, 8, rx);
		for (int i = 0; i < nbytes; i++) begin
			gap();
			shift(rd ? 8'h00 : wd[15 - 8 * i -: 8], (i == nbytes - 1) ? last_bits : 8, rx);
			if (rd) begin
				rd_byte_o <= rx;
				rd_stb_o  <= 1'b1;
				@(posedge clock_i);
				rd_stb_o <= 1'b0;
			end
		end
		gap();
		cs_n_o <= 1'b1;
		mosi_o <= ~mosi_o;
		gap();
	endtask : frame
endmodule : spi_host_model
`default_nettype wire

// *** bench/inductive_sensor_spi_power_control_tb_top.sv ***
// Self-checking testbench of the sensor serial interface with power control.
`timescale 1ns/1ps
`default_nettype none
module inductive_sensor_spi_power_control_tb_top
	import ind_pkg::*;
;
	logic         clock_i;
	logic         rst_n_i;
	logic         conv_done_i;
	logic         osc_lost_i;
	logic         ref_run;
	logic [3:0]   thr_flags_i;
	reg_byte_t    fine_status;
	logic         sclk;
	logic         cs_n;
	logic         mosi;
	logic         sdo;
	logic         sdo_oe;
	logic         ref_clk;
	logic         conv_en;
	logic         rd_stb;
	logic [7:0]   rd_byte;
	power_state_t pstate;
	int           miscompares;
	int           check_count;
	logic [7:0]   exp_q[$];
	logic [7:0]   r1;
	logic [7:0]   r2;
	logic [3:0]   t;

	inductive_sensor_spi_power_control u_dut (
		.clock_i                  (clock_i),
		.rst_n_i                  (rst_n_i),
		.sclk_i                   (sclk),
		.chip_select_active_low_i (cs_n),
		.mosi_i                   (mosi),
		.sdo_o                    (sdo),
		.sdo_oe_o                 (sdo_oe),
		.reference_clock_input_i  (ref_clk),
		.conv_done_i              (conv_done_i),
		.thr_flags_i              (thr_flags_i),
		.osc_lost_i               (osc_lost_i),
		.fine_inductance_status_i (fine_status),
		.conv_enable_o            (conv_en),
		.power_state_o            (pstate)
	);

	spi_host_model u_host (
		.clock_i   (clock_i),
		.ref_run_i (ref_run),
		.sdo_i     (sdo),
		.sclk_o    (sclk),
		.cs_n_o    (cs_n),
		.mosi_o    (mosi),
		.ref_clk_o (ref_clk),
		.rd_stb_o  (rd_stb),
		.rd_byte_o (rd_byte)
	);

	initial clock_i = 1'b0;
	always #50 clock_i = ~clock_i;

	//********************************************************
	// Comparison and closing
	//********************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish();
		if (miscompares == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// Read results are compared against the oldest expectation noted by the driver.
	always @(posedge clock_i) begin
		if (rd_stb === 1'b1) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("[ERR] t=%0t seen=%h exp=--", $time, rd_byte);
			end else begin
				check(rd_byte, exp_q.pop_front());
			end
		end
	end

	//********************************************************
	// Driver tasks
	//********************************************************
	task automatic wr(input logic [6:0] a, input int n, input logic [15:0] wd);
		u_host.frame(1'b0, a, n, 8, wd);
	endtask : wr

	task automatic rd(input logic [6:0] a, input int n, input logic [39:0] e);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(e[8 * (n - 1 - i) +: 8]);
		end
		u_host.frame(1'b1, a, n, 8, 16'h0000);
	endtask : rd

	task automatic wait_state(input power_state_t s);
		for (int i = 0; i < 60 && pstate !== s; i++) begin
			@(posedge clock_i);
		end
		check({6'h00, pstate}, {6'h00, s});
		if (pstate !== s) begin
			tally_and_finish();
		end
	endtask : wait_state

	task automatic pulse(input logic [3:0] f);
		@(posedge clock_i);
		conv_done_i <= 1'b1;
		thr_flags_i <= f;
		@(posedge clock_i);
		conv_done_i <= 1'b0;
	endtask : pulse

	//********************************************************
	// Main sequence
	//********************************************************
	initial begin
		rst_n_i = 1'b0;
		conv_done_i = 1'b0;
		osc_lost_i = 1'b0;
		ref_run = 1'b1;
		thr_flags_i = 4'h0;
		miscompares = 0;
		check_count = 0;
		void'($urandom(16));
		r1 = 8'($urandom());
		r2 = 8'($urandom());
		t = 4'($urandom());
		fine_status = 8'($urandom());
		repeat (6) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		#1;
		check({6'h00, pstate}, {6'h00, PWR_POR});
		wait_state(PWR_SLEEP);
		rd(7'h20, 1, 40'h00);
		rd(7'h01, 5, 40'h0790a00300);
		rd(7'h0b, 1, 40'h01);
		rd(7'h3b, 1, {32'h0, fine_status});
		rd(7'h40, 1, 40'h00);
		wr(7'h06, 2, {r1, r2});
		rd(7'h06, 2, {24'h0, r1, r2});
		u_host.frame(1'b0, 7'h08, 1, 5, 16'hff00);
		rd(7'h08, 1, 40'h00);
		wr(7'h0b, 1, 16'h0000);
		wait_state(PWR_ACTIVE);
		check({7'h00, conv_en}, 8'h01);
		wr(7'h0a, 1, 16'h0100);
		wr(7'h01, 1, 16'h5500);
		pulse(t);
		osc_lost_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		#1;
		check({7'h00, sdo}, 8'h00);
		check({7'h00, sdo_oe}, 8'h01);
		rd(7'h20, 1, {32'h0, 2'b11, t, 2'b00});
		rd(7'h01, 1, 40'h07);
		wr(7'h0a, 1, 16'h0200);
		repeat (3) @(posedge clock_i);
		#1;
		check({7'h00, sdo}, {7'h00, ~t[3]});
		wr(7'h0a, 1, 16'h0300);
		repeat (3) @(posedge clock_i);
		#1;
		check({7'h00, sdo}, {7'h00, ~t[1]});
		wr(7'h0b, 1, 16'h0100);
		wait_state(PWR_SLEEP);
		check({7'h00, conv_en}, 8'h00);
		pulse(4'hf);
		rd(7'h20, 1, {32'h0, 2'b10, t, 2'b00});
		rd(7'h06, 1, {32'h0, r1});
		wr(7'h0b, 1, 16'h0200);
		repeat (12) @(posedge clock_i);
		check({6'h00, pstate}, {6'h00, PWR_SLEEP});
		wr(7'h05, 1, 16'h0200);
		@(posedge clock_i);
		ref_run <= 1'b0;
		repeat (4) @(posedge clock_i);
		wr(7'h0b, 1, 16'h0200);
		wait_state(PWR_SHUT);
		check({7'h00, conv_en}, 8'h00);
		@(posedge clock_i);
		ref_run <= 1'b1;
		wait_state(PWR_SLEEP);
		check({7'h00, sdo_oe}, 8'h00);
		rd(7'h05, 2, {24'h0, 8'h00, 8'h00});
		rd(7'h0b, 1, 40'h01);
		rd(7'h20, 1, 40'h80);
		check(8'(exp_q.size()), 8'h00);
		tally_and_finish();
	end
endmodule : inductive_sensor_spi_power_control_tb_top
`default_nettype wire
